// ---- common/xpt_if.sv ----
// Purpose: Pin bundle between the crosspoint host and the crosspoint device
// Assumes: All pins are plain one-way levels, synchronous to mclk
// Notes: No two-way pins exist on this port
`timescale 1ns/10ps
interface xpt_if;
    logic chip_select_n;
    logic serial_parallel_select;
    logic update_n;
    logic shift_clk_n;
    logic write_strobe_n;
    logic init_clear_qualifier;
    logic [2:0] output_select;
    logic [4:0] prog_data;
    logic serial_data_in;
    logic reset_n;
    logic serial_data_out;
    modport host (output chip_select_n, serial_parallel_select, update_n, shift_clk_n,
        write_strobe_n, init_clear_qualifier, output_select, prog_data, serial_data_in,
        reset_n, input serial_data_out);
    modport dev (input chip_select_n, serial_parallel_select, update_n, shift_clk_n,
        write_strobe_n, init_clear_qualifier, output_select, prog_data, serial_data_in,
        reset_n, output serial_data_out);
endinterface

// ---- common/xpt_pkg.sv ----
// Purpose: Shared constants for the crosspoint programming port and its host
// Assumes: One synchronous clock mclk at 100 MHz drives both ends
// Notes: Pins are sampled as synchronous levels; edges are found by comparison
package xpt_pkg;
    localparam int NUM_OUTPUTS = 5;
    localparam int SEL_W = 4;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 5;
    localparam int EN_BIT = 4;
    localparam int PAD_BITS = 5;
    localparam int SERIAL_BITS = 45;
    localparam int SER_CNT_W = 6;
    localparam logic [DATA_W-1:0] OFF_WORD = 5'h00;
    localparam logic [2:0] TOP_OUTPUT = 3'h4;
    // Host pin phase lengths, in mclk cycles
    localparam int PHASE_CYC = 2;
    localparam int PH_W = 2;
    // Host AXI4-Lite register offsets and fields
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam logic [3:0] REG_SHADOW = 4'h8;
    localparam int CMD_START = 0;
    localparam int CMD_WRITE = 1;
    localparam int CMD_APPLY = 2;
    localparam int CMD_INIT = 3;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_DATA_LSB = 16;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {ACT_WRITE, ACT_APPLY, ACT_INIT} act_t;
endpackage

// ---- dv/testbench.sv ----
// Purpose: End-to-end check of host and crosspoint through the pin bundle
// Assumes: AXI4-Lite master at 100 MHz, one command at a time
// Notes: Model keeps staged and live words; disabled outputs skip input check
`timescale 1ns/10ps
module testbench;
    import xpt_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, d;
    logic [4:0] out_en;
    logic [19:0] out_sel;
    int miscompares = 0, n_tests = 0, cyc = 0;
    int live[5], stage[5];
    int a, w;

    xpt_if pins_if();
    xpt_host xpt_host_i(.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pins(pins_if.host));
    xpt_matrix xpt_matrix_i(.mclk(mclk), .rst_n(rst_n), .pins(pins_if.dev),
        .out_enable(out_en), .out_input_sel(out_sel));
    xpt_pins_chk xpt_pins_chk_i(.mclk(mclk), .rst_n(rst_n),
        .chip_select_n(pins_if.chip_select_n), .update_n(pins_if.update_n),
        .serial_parallel_select(pins_if.serial_parallel_select),
        .shift_clk_n(pins_if.shift_clk_n), .write_strobe_n(pins_if.write_strobe_n),
        .init_clear_qualifier(pins_if.init_clear_qualifier),
        .output_select(pins_if.output_select), .prog_data(pins_if.prog_data),
        .serial_data_in(pins_if.serial_data_in));

    // Clock
    initial forever #5 mclk = ~mclk;

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Leading edge keeps a released ready from being raised in the same step
    task automatic axi_wr(input logic [3:0] ad, input logic [31:0] v);
        @(posedge mclk);
        awaddr <= ad;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] ad);
        @(posedge mclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Issue a command, check its response, then wait until the host is idle
    task automatic run_cmd(input logic [3:0] fl, input int ad, input int v, input logic [1:0] e);
        axi_wr(REG_CMD, {11'h0, v[4:0], 5'h0, ad[2:0], 4'h0, fl});
        check("response", e, r);
        do axi_rd(REG_STAT); while (d[0] !== 1'b0);
    endtask

    task automatic cmp_matrix();
        for (int k = 0; k < NUM_OUTPUTS; k++) begin
            check("enable", live[k][4], out_en[k]);
            if (live[k][4]) check("input", live[k][3:0], out_sel[4*k+:4]);
        end
    endtask

    initial begin
        void'($urandom(44));
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        run_cmd(4'h5, 0, 0, RESP_SLVERR);
        $display("test refused apply done");
        // Two-step init from the shadow words
        for (int k = 0; k < NUM_OUTPUTS; k++) begin
            w = $urandom_range(31, 0);
            axi_wr(REG_SHADOW, {11'h0, w[4:0], 5'h0, k[2:0], 8'h0});
            live[k] = w;
            stage[k] = w;
        end
        run_cmd(4'h9, 0, 0, RESP_OKAY);
        axi_rd(REG_STAT);
        check("init done", 32'h1, {31'h0, d[1]});
        cmp_matrix();
        $display("test init done");
        // Staged writes, some applied at once, some held for a later apply
        for (int i = 0; i < 16; i++) begin
            a = $urandom_range(4, 0);
            w = $urandom_range(31, 0);
            stage[a] = w;
            if (i % 3 == 0) begin
                run_cmd(4'h7, a, w, RESP_OKAY);
                live = stage;
            end else begin
                run_cmd(4'h3, a, w, RESP_OKAY);
            end
            cmp_matrix();
            if (i % 4 == 3) begin
                run_cmd(4'h5, 0, 0, RESP_OKAY);
                live = stage;
                cmp_matrix();
            end
        end
        $display("test staged writes done");
        // Reset pin disables outputs but keeps the live programming
        rst_n <= 1'b0;
        repeat (10) @(posedge mclk);
        check("reset enables", 32'h0, {27'h0, out_en});
        rst_n <= 1'b1;
        axi_rd(REG_STAT);
        cmp_matrix();
        $display("test reset pin done");
        // Unmapped place
        axi_wr(4'hC, $urandom);
        check("unmapped resp", RESP_OKAY, r);
        axi_rd(4'hC);
        check("unmapped read", 32'h0, d);
        check("read resp", RESP_OKAY, r);
        $display("test unmapped done");
        give_verdict();
    end
endmodule // testbench

// ---- dv/xpt_pins_assertions.sv ----
// Purpose: Pin-level checks on the host-to-crosspoint bundle
// Assumes: One clock mclk; rst_n is the host reset
// Notes: Sees only the pins, so device outputs are checked by the bench
`timescale 1ns/10ps
module xpt_pins_chk
    import xpt_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic chip_select_n, // Chip select
    input wire logic serial_parallel_select, // Mode select
    input wire logic update_n, // Update
    input wire logic shift_clk_n, // Shift clock
    input wire logic write_strobe_n, // Write strobe
    input wire logic init_clear_qualifier, // Clear
    input wire logic [2:0] output_select, // Output code
    input wire logic [4:0] prog_data, // Data word
    input wire logic serial_data_in // Serial data
);
    logic [2:0] last_sel_ff;
    logic last_clr_ff;
    logic loaded_ff; // Off words reached output zero; a serial-only load is not seen here

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Remember the last strobed output so the init order can be followed
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            last_clr_ff <= 1'b0;
            loaded_ff <= 1'b0;
        end else if ($fell(write_strobe_n)) begin
            last_sel_ff <= output_select;
            last_clr_ff <= init_clear_qualifier;
            if (init_clear_qualifier && output_select == 3'h0) begin
                loaded_ff <= 1'b1;
            end
        end
    end

    mode_pins_a: assert property (!chip_select_n && serial_parallel_select && shift_clk_n
        && !serial_data_in) else $error("parallel mode pins wrong");
    strobe_width_a: assert property ($fell(write_strobe_n) |-> ##1 !write_strobe_n
        ##1 write_strobe_n) else $error("strobe low time wrong");
    strobe_idle_a: assert property ($fell(write_strobe_n) |-> $past(write_strobe_n, 2))
        else $error("strobe not idle high before fall");
    strobe_data_a: assert property ($fell(write_strobe_n) |->
        ($stable(output_select) && $stable(prog_data))
        ##1 ($stable(output_select) && $stable(prog_data)))
        else $error("address or data moved around strobe");
    upd_vs_strobe_a: assert property (!write_strobe_n |-> update_n)
        else $error("update low during strobe");
    upd_width_a: assert property ($fell(update_n) |-> ##1 !update_n ##1 update_n)
        else $error("update low time wrong");
    upd_after_load_a: assert property ($fell(update_n) |-> loaded_ff)
        else $error("update low before staging was loaded");
    init_off_a: assert property ($fell(write_strobe_n) && init_clear_qualifier
        |-> prog_data == OFF_WORD) else $error("clear strobe word not off");
    init_order_a: assert property ($fell(write_strobe_n) && init_clear_qualifier
        |-> output_select == (last_clr_ff ? last_sel_ff - 3'h1 : TOP_OUTPUT))
        else $error("init order wrong");
    clear_steady_a: assert property (!write_strobe_n |-> $stable(init_clear_qualifier))
        else $error("clear moved during strobe");
endmodule // xpt_pins_chk

// ---- rtl/xpt_host.sv ----
// Purpose: Host controller driving the crosspoint parallel programming pins
// Assumes: Software commands arrive over AXI4-Lite, one action at a time
// Notes: Each pin phase lasts PHASE_CYC cycles so the device sees clean edges
`timescale 1ns/10ps
module xpt_host
    import xpt_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic [3:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [3:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    xpt_if.host pins // Pins toward the crosspoint
);
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_RELEASE, S_UPD, S_NEXT} st_t;
    st_t st_ff;
    logic [PH_W-1:0] ph_ff;
    act_t act_ff;
    logic [2:0] addr_ff;
    logic [DATA_W-1:0] data_ff;
    logic init_pass_ff; // 0: all off with clear high, 1: wanted state
    logic [DATA_W-1:0] want_ff [NUM_OUTPUTS];
    logic ready_init_ff; // Set once the clear pass has staged off words in every output
    logic strobe_n_ff, upd_n_ff, clr_ff;
    logic awr_ff, wr_ff, bv_ff, arr_ff, rv_ff;
    logic [1:0] bresp_ff;
    logic [31:0] rdata_ff;

    wire busy = (st_ff != S_IDLE);
    wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bv_ff & ~awr_ff;
    wire wr_cmd = wr_go & (s_axi_awaddr == REG_CMD) & s_axi_wstrb[0];
    wire wr_shadow = wr_go & (s_axi_awaddr == REG_SHADOW);
    wire cmd_start = wr_cmd & s_axi_wdata[CMD_START] & ~busy;
    // Stage first when writing or initialising; a bare apply goes straight to update
    wire go_stage = s_axi_wdata[CMD_WRITE] | s_axi_wdata[CMD_INIT];
    wire go_apply = s_axi_wdata[CMD_APPLY] & ~go_stage;
    // Apply before the init clear pass has finished is refused so random staging never reaches the matrix
    wire apply_ok = ready_init_ff | ~s_axi_wdata[CMD_APPLY];
    wire phase_done = (ph_ff == PH_W'(PHASE_CYC - 1));
    wire rd_go = s_axi_arvalid & ~rv_ff & ~arr_ff;
    wire [31:0] rd_word = (s_axi_araddr == REG_STAT) ? {30'h0, ready_init_ff, busy} :
        (s_axi_araddr == REG_CMD) ? {8'h0, 3'h0, data_ff, 5'h0, addr_ff, 8'h0} : 32'h0;

    // AXI4-Lite handshakes; address and data are taken together
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            awr_ff <= 1'b0;
            wr_ff <= 1'b0;
            bv_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            arr_ff <= 1'b0;
            rv_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            awr_ff <= wr_go;
            wr_ff <= wr_go;
            if (wr_go) begin
                bresp_ff <= (wr_cmd & (busy | ~apply_ok)) ? RESP_SLVERR : RESP_OKAY;
            end
            // Answers only follow the edge at which the ready pulse completes the handshake
            if (awr_ff) begin
                bv_ff <= 1'b1;
            end else if (s_axi_bready) begin
                bv_ff <= 1'b0;
            end
            arr_ff <= rd_go;
            if (arr_ff) begin
                rv_ff <= 1'b1;
                rdata_ff <= rd_word;
            end else if (s_axi_rready) begin
                rv_ff <= 1'b0;
            end
        end
    end

    // Wanted output words used by the initialization pass
    always_ff @(posedge mclk) begin
        if (wr_shadow) begin
            want_ff[s_axi_wdata[CMD_ADDR_LSB +: ADDR_W]] <= s_axi_wdata[CMD_DATA_LSB +: DATA_W];
        end
    end

    // Pin sequencer: setup, strobe low, strobe high, optional update pulse
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_ff <= S_IDLE;
            ph_ff <= '0;
            act_ff <= ACT_WRITE;
            addr_ff <= '0;
            data_ff <= OFF_WORD;
            init_pass_ff <= 1'b0;
            ready_init_ff <= 1'b0;
            strobe_n_ff <= 1'b1;
            upd_n_ff <= 1'b1;
            clr_ff <= 1'b0;
        end else begin
            ph_ff <= (busy && !phase_done) ? ph_ff + PH_W'(1) : '0;
            unique case (st_ff)
                S_IDLE: if (cmd_start && apply_ok) begin
                    addr_ff <= s_axi_wdata[CMD_ADDR_LSB +: ADDR_W];
                    data_ff <= s_axi_wdata[CMD_DATA_LSB +: DATA_W];
                    if (s_axi_wdata[CMD_INIT]) begin
                        act_ff <= ACT_INIT;
                        addr_ff <= TOP_OUTPUT;
                        data_ff <= OFF_WORD;
                        init_pass_ff <= 1'b0;
                        clr_ff <= 1'b1;
                    end else begin
                        act_ff <= s_axi_wdata[CMD_APPLY] ? ACT_APPLY : ACT_WRITE;
                    end
                    // A start with neither staging nor apply loads the address and data pins but pulses neither strobe nor update
                    st_ff <= go_stage ? S_SETUP : (go_apply ? S_UPD : S_IDLE);
                    if (go_apply) begin
                        upd_n_ff <= 1'b0;
                    end
                end
                S_SETUP: if (phase_done) begin
                    strobe_n_ff <= 1'b0;
                    st_ff <= S_STROBE;
                end
                S_STROBE: if (phase_done) begin
                    strobe_n_ff <= 1'b1;
                    st_ff <= S_RELEASE;
                end
                S_RELEASE: if (phase_done) begin
                    if (act_ff == ACT_INIT) begin
                        st_ff <= S_NEXT;
                    end else begin
                        st_ff <= (act_ff == ACT_APPLY) ? S_UPD : S_IDLE;
                        if (act_ff == ACT_APPLY) upd_n_ff <= 1'b0;
                    end
                end
                // A full phase here keeps the next setup and the update low at two cycles
                S_NEXT: if (phase_done) begin
                    if (addr_ff != '0) begin
                        // Stage outputs from the top down, update held high
                        addr_ff <= addr_ff - 3'h1;
                        data_ff <= init_pass_ff ? want_ff[addr_ff - 3'h1] : OFF_WORD;
                        st_ff <= S_SETUP;
                    end else begin
                        upd_n_ff <= 1'b0;
                        if (!init_pass_ff) ready_init_ff <= 1'b1;
                        st_ff <= S_UPD;
                    end
                end
                S_UPD: begin
                    upd_n_ff <= 1'b0;
                    if (phase_done) begin
                        upd_n_ff <= 1'b1;
                        if (act_ff == ACT_INIT && !init_pass_ff) begin
                            init_pass_ff <= 1'b1;
                            clr_ff <= 1'b0;
                            addr_ff <= TOP_OUTPUT;
                            data_ff <= want_ff[TOP_OUTPUT];
                            st_ff <= S_SETUP;
                        end else begin
                            st_ff <= S_IDLE;
                        end
                    end
                end
                default: st_ff <= S_IDLE;
            endcase
        end
    end

    assign s_axi_awready = awr_ff;
    assign s_axi_wready = wr_ff;
    assign s_axi_bvalid = bv_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arr_ff;
    assign s_axi_rvalid = rv_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = RESP_OKAY;
    // Parallel mode pin levels held for the whole operation
    assign pins.chip_select_n = 1'b0;
    assign pins.serial_parallel_select = 1'b1;
    assign pins.shift_clk_n = 1'b1;
    assign pins.serial_data_in = 1'b0;
    assign pins.reset_n = rst_n;
    assign pins.write_strobe_n = strobe_n_ff;
    assign pins.update_n = upd_n_ff;
    assign pins.init_clear_qualifier = clr_ff;
    assign pins.output_select = addr_ff;
    assign pins.prog_data = data_ff;
endmodule // xpt_host

// ---- rtl/xpt_matrix.sv ----
// Purpose: Programming logic of a five-output, sixteen-input crosspoint matrix
// Assumes: Pins sampled on mclk; rst_n is only the simulation-side bring-up
// Notes: Staging and live state carry no reset, mirroring unknown power-up content
`timescale 1ns/10ps
module xpt_matrix
    import xpt_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic rst_n, // Synchronous reset of sampling flops
    xpt_if.dev pins, // Programming pins from the host
    output logic [NUM_OUTPUTS-1:0] out_enable, // Live enable per output
    output logic [NUM_OUTPUTS*SEL_W-1:0] out_input_sel // Live input per output
);
    logic strobe_prev_ff;
    logic shclk_prev_ff;
    // Staging: five words; serial chain is 45 bits through the same storage
    logic [SERIAL_BITS-1:0] shift_ff;
    logic [DATA_W-1:0] live_ff [NUM_OUTPUTS];
    logic [NUM_OUTPUTS-1:0] en_ff;
    logic [NUM_OUTPUTS*SEL_W-1:0] sel_ff;
    logic sdo_ff;

    // Chip select gates shift clock and update to their idle high level
    wire shclk_g = pins.chip_select_n | pins.shift_clk_n;
    wire update_g_n = pins.chip_select_n | pins.update_n;
    wire strobe_fall = strobe_prev_ff & ~pins.write_strobe_n;
    wire par_write = strobe_fall & pins.serial_parallel_select;
    wire ser_shift = shclk_prev_ff & ~shclk_g & ~pins.serial_parallel_select;
    // Serial input sits below bit zero, so every slice shifts in from its lower neighbour
    wire [SERIAL_BITS:0] chain = {shift_ff, pins.serial_data_in};

    // Edge detectors on the write strobe and gated shift clock
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strobe_prev_ff <= 1'b1;
            shclk_prev_ff <= 1'b1;
        end else begin
            strobe_prev_ff <= pins.write_strobe_n;
            shclk_prev_ff <= shclk_g;
        end
    end

    // Staging register; word k sits at the bits that the serial order leaves it in.
    // Top output lands at the high end after 45 shifts, padding fills the gaps.
    genvar k;
    generate
        for (k = 0; k < NUM_OUTPUTS; k++) begin : g_out
            localparam int LSB = k * (DATA_W + PAD_BITS);
            wire hit = par_write && (pins.output_select == ADDR_W'(k));
            always_ff @(posedge mclk) begin
                if (hit) begin
                    shift_ff[LSB +: DATA_W] <= pins.prog_data;
                end else if (ser_shift) begin
                    shift_ff[LSB +: DATA_W] <= chain[LSB +: DATA_W];
                end
                // Transparent latch modelled as a follow-every-cycle copy
                if (!update_g_n) begin
                    live_ff[k] <= shift_ff[LSB +: DATA_W];
                end
            end
            if (k < NUM_OUTPUTS - 1) begin : g_pad
                always_ff @(posedge mclk) begin
                    if (ser_shift) begin
                        shift_ff[LSB+DATA_W +: PAD_BITS] <= chain[LSB+DATA_W +: PAD_BITS];
                    end
                end
            end
            // Reset overrides enable only; disabled output ignores input select
            always_ff @(posedge mclk) begin
                en_ff[k] <= pins.reset_n & live_ff[k][EN_BIT];
                sel_ff[k*SEL_W +: SEL_W] <= live_ff[k][SEL_W-1:0];
            end
        end
    endgenerate

    // Serial output is the far end of the chain, for daisy chaining
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sdo_ff <= 1'b0;
        end else begin
            sdo_ff <= shift_ff[SERIAL_BITS-1];
        end
    end

    assign pins.serial_data_out = sdo_ff;
    assign out_enable = en_ff;
    assign out_input_sel = sel_ff;
endmodule // xpt_matrix
